// >>> verilog/sbic_map.vh
// Constants for the sensor bus ID check and cycle block
// Behaviour
// RULE1: each address detection run checks every slave for duplicated IDs.
// RULE2: duplicate found sets slave alarm and fault code 0190H.
// RULE3: duplicated ID goes to fault ID word, brief bits and host alarm.
// RULE4: repeated duplicate or unset IDs report one alarm ID, count one.
// RULE5: after power cycle, status stays hidden until detection reruns.
// RULE6: bus bit transmission keeps running while status is flagged.
// RULE7: IDs 02FFH and 00FFH are unset; store that ID in all reports.
// RULE8: unset ID sets slave alarm and fault code 0191H.
// RULE9: simultaneous errors show only the latest in code and ID fields.
// RULE10: code, ID words and host alarms only in extended host mode.
// RULE11: status clears on bus reset or clear flag on then off.
// RULE12: test mode runs bus alone, no host link; not entered when linked.
// RULE13: three setup presses without host link: setup, alarm, then link flash.
// RULE14: test entry shown by link lamp flashing, setup and alarm lamps off.
// RULE15: test mode is left only by reset.
// RULE16: cycle 3.5 ms at 128 points, 5.9 ms at 256 points.
// RULE17: cycle 8.3 ms at 384 points, 10.6 ms at 512 points.
// RULE18: input area updates only after two identical consecutive receptions.
// RULE19: slave inputs should be held longer than two cycle times.
// RULE20: slaves double check output data likewise.
// RULE21: add 0.6 ms processing each way between bus and host.
// RULE22: clearing drops alarm flag and zeroes code, ID and brief fields.
// RULE23: clear request acts on its on-to-off edge after seen on.
`ifndef SBIC_MAP_VH
`define SBIC_MAP_VH
`define SBIC_CODE_DUP      16'h0190
`define SBIC_CODE_UNSET    16'h0191
`define SBIC_ID_UNSET_IN   12'h2FF
`define SBIC_ID_UNSET_OUT  12'h0FF
`define SBIC_CLK_KHZ       25000
// Cycle times in microseconds
`define SBIC_CYC_128_US    3500
`define SBIC_CYC_256_US    5900
`define SBIC_CYC_384_US    8300
`define SBIC_CYC_512_US    10600
`define SBIC_PROC_US       600
`define SBIC_FLASH_US      250000
// Point setting encodings
`define SBIC_PTS_128       2'h0
`define SBIC_PTS_256       2'h1
`define SBIC_PTS_384       2'h2
`define SBIC_PTS_512       2'h3
`define SBIC_PRESS_DONE    2'h3
`endif

// >>> verilog/sbic_dchk.v
// Double check filter: accepts a word seen on two consecutive cycles
`timescale 1ns/1ps
module sbic_dchk #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst,
  // Received word and its cycle strobe
  input  wire [W-1:0] rx_data,
  input  wire         rx_stb,
  // Accepted word
  output reg  [W-1:0] acc_data_r,
  output reg          acc_upd_r
);
  reg [W-1:0] prev_r;
  reg         prev_ok_r;

  // Compare with the previous cycle's word
  always @(posedge clk_sys) begin
    if (rst) begin
      prev_r     <= {W{1'b0}};
      prev_ok_r  <= 1'b0;
      acc_data_r <= {W{1'b0}};
      acc_upd_r  <= 1'b0;
    end else begin
      acc_upd_r <= 1'b0;
      if (rx_stb) begin
        prev_r    <= rx_data;
        prev_ok_r <= 1'b1;
        if (prev_ok_r && prev_r == rx_data) begin // see RULE18
          acc_data_r <= rx_data;
          acc_upd_r  <= 1'b1;
        end
      end
    end
  end
endmodule // sbic_dchk

// >>> verilog/sbic_top.v
// Sensor bus ID check, error report, test mode and cycle timing
`timescale 1ns/1ps
`include "sbic_map.vh"
module sbic_top #(
  parameter IN_W       = 16,
  parameter CYC128_CNT = (`SBIC_CYC_128_US * (`SBIC_CLK_KHZ / 1000)),
  parameter CYC256_CNT = (`SBIC_CYC_256_US * (`SBIC_CLK_KHZ / 1000)),
  parameter CYC384_CNT = (`SBIC_CYC_384_US * (`SBIC_CLK_KHZ / 1000)),
  parameter CYC512_CNT = (`SBIC_CYC_512_US * (`SBIC_CLK_KHZ / 1000)),
  parameter PROC_CNT   = (`SBIC_PROC_US * (`SBIC_CLK_KHZ / 1000)),
  parameter FLASH_CNT  = (`SBIC_FLASH_US * (`SBIC_CLK_KHZ / 1000))
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // Configuration
  input  wire [1:0]        io_points_sel,
  input  wire              ext_mode,
  // Host link pins
  input  wire              host_link_pin,
  input  wire              fault_clear_request_main,
  input  wire              fault_clear_request_alt,
  // Setup button pin
  input  wire              setup_btn_pin,
  // Address detection results, one per detected slave
  input  wire              det_start,
  input  wire              det_id_stb,
  input  wire [11:0]       det_id,
  input  wire              det_dup,
  input  wire              det_done,
  // Bus receive word, strobed once per cycle by the bus engine
  input  wire [IN_W-1:0]   bus_rx_data,
  input  wire              bus_rx_stb,
  // Host output word
  input  wire [IN_W-1:0]   host_out_data,
  // Reports
  output reg               slave_alarm_r,
  output reg  [15:0]       latest_fault_code_word,
  output reg  [15:0]       latest_fault_id_word,
  output reg  [9:0]        fault_id_brief_bits,
  output reg               host_alarm_r,
  output reg  [11:0]       host_alarm_id_r,
  output reg  [7:0]        host_alarm_cnt_r,
  // Bus cycle and data
  output reg               bus_cycle_stb_r,
  output reg               bus_tx_run_r,
  output reg  [IN_W-1:0]   bus_tx_data_r,
  output reg  [IN_W-1:0]   host_in_data_r,
  output reg               host_in_upd_r,
  // Mode and lamps
  output reg               test_mode_r,
  output reg               host_comm_en_r,
  output reg               setup_lamp,
  output reg               alarm_lamp,
  output reg               bus_link_lamp
);
  //--------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------
  reg [1:0] link_s_r;
  reg [1:0] clrm_s_r;
  reg [1:0] clra_s_r;
  reg [1:0] btn_s_r;
  reg       btn_d_r;

  // Two flops per pin, then a button edge register
  always @(posedge clk_sys) begin
    if (rst) begin
      link_s_r <= 2'h0;
      clrm_s_r <= 2'h0;
      clra_s_r <= 2'h0;
      btn_s_r  <= 2'h0;
      btn_d_r  <= 1'b0;
    end else begin
      link_s_r <= {link_s_r[0], host_link_pin};
      clrm_s_r <= {clrm_s_r[0], fault_clear_request_main};
      clra_s_r <= {clra_s_r[0], fault_clear_request_alt};
      btn_s_r  <= {btn_s_r[0], setup_btn_pin};
      btn_d_r  <= btn_s_r[1];
    end
  end

  wire link_up   = link_s_r[1];
  wire clr_req   = clrm_s_r[1] | clra_s_r[1];
  wire btn_press = btn_s_r[1] & ~btn_d_r;

  //--------------------------------------------------------------
  // Clear request edge detect
  //--------------------------------------------------------------
  reg  clr_seen_r;
  wire clr_fire = clr_seen_r & ~clr_req; // see RULE23

  // Arm on on, fire once on off
  always @(posedge clk_sys) begin
    if (rst) begin
      clr_seen_r <= 1'b0;
    end else begin
      clr_seen_r <= clr_req; // see RULE11
    end
  end

  //--------------------------------------------------------------
  // Address check and error report
  //--------------------------------------------------------------
  wire id_unset = (det_id == `SBIC_ID_UNSET_IN) ||
                  (det_id == `SBIC_ID_UNSET_OUT); // see RULE7
  wire id_err   = det_id_stb & (det_dup | id_unset); // see RULE1
  reg  [11:0] last_id_r;
  reg         have_id_r;

  // Latch the newest error; reset and clear zero all fields
  always @(posedge clk_sys) begin
    if (rst) begin
      slave_alarm_r          <= 1'b0;
      latest_fault_code_word <= 16'h0000;
      latest_fault_id_word   <= 16'h0000;
      fault_id_brief_bits    <= 10'h000;
      host_alarm_r           <= 1'b0;
      host_alarm_id_r        <= 12'h000;
      host_alarm_cnt_r       <= 8'h00;
      last_id_r              <= 12'h000;
      have_id_r              <= 1'b0;
    end else if (id_err) begin
      // Error wins over a clear in the same cycle
      slave_alarm_r       <= 1'b1; // see RULE2
      fault_id_brief_bits <= det_id[9:0]; // see RULE3
      if (ext_mode) begin // see RULE10
        latest_fault_code_word <= id_unset ? `SBIC_CODE_UNSET
                                           : `SBIC_CODE_DUP; // see RULE8
        latest_fault_id_word   <= {4'h0, det_id}; // see RULE9
        host_alarm_r           <= 1'b1;
        host_alarm_id_r        <= det_id;
        last_id_r              <= det_id;
        have_id_r              <= 1'b1;
        // One alarm ID per repeated address
        if (!(have_id_r && last_id_r == det_id)) begin // see RULE4
          host_alarm_cnt_r <= 8'h01;
        end
      end
    end else if (clr_fire || det_start) begin
      // see RULE22
      // see RULE5
      slave_alarm_r          <= 1'b0;
      latest_fault_code_word <= 16'h0000;
      latest_fault_id_word   <= 16'h0000;
      fault_id_brief_bits    <= 10'h000;
      host_alarm_r           <= 1'b0;
      host_alarm_id_r        <= 12'h000;
      host_alarm_cnt_r       <= 8'h00;
      have_id_r              <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // Test mode entry by button sequence
  //--------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_P1   = 2'h1;
  localparam ST_P2   = 2'h2;
  localparam ST_TEST = 2'h3;
  reg [1:0]  st_r;
  reg [1:0]  st_nxt;
  reg        linked_ever_r;

  // Next state of the entry sequence
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (btn_press && !linked_ever_r) begin
          st_nxt = ST_P1; // see RULE13
        end
      end
      ST_P1: begin
        if (linked_ever_r) begin
          st_nxt = ST_IDLE;
        end else if (btn_press) begin
          st_nxt = ST_P2;
        end
      end
      ST_P2: begin
        if (linked_ever_r) begin
          st_nxt = ST_IDLE; // see RULE12
        end else if (btn_press) begin
          st_nxt = ST_TEST;
        end
      end
      ST_TEST: begin
        st_nxt = ST_TEST; // see RULE15
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // State register and host link history
  always @(posedge clk_sys) begin
    if (rst) begin
      st_r          <= ST_IDLE;
      linked_ever_r <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      linked_ever_r <= linked_ever_r | (link_up && st_r != ST_TEST);
    end
  end

  //--------------------------------------------------------------
  // Lamps and flash timer
  //--------------------------------------------------------------
  reg [23:0] flash_cnt_r;
  reg        flash_r;

  // Free running flash toggle
  always @(posedge clk_sys) begin
    if (rst) begin
      flash_cnt_r <= 24'h000000;
      flash_r     <= 1'b0;
    end else if (flash_cnt_r == FLASH_CNT[23:0] - 24'h000001) begin
      flash_cnt_r <= 24'h000000;
      flash_r     <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 24'h000001;
    end
  end

  // Lamp drive per entry stage
  always @(posedge clk_sys) begin
    if (rst) begin
      setup_lamp     <= 1'b0;
      alarm_lamp     <= 1'b0;
      bus_link_lamp  <= 1'b0;
      test_mode_r    <= 1'b0;
      host_comm_en_r <= 1'b0;
    end else begin
      test_mode_r    <= (st_r == ST_TEST);
      host_comm_en_r <= (st_r != ST_TEST) && link_up; // see RULE12
      case (st_r)
        ST_TEST: begin
          setup_lamp    <= 1'b0; // see RULE14
          alarm_lamp    <= 1'b0;
          bus_link_lamp <= flash_r;
        end
        ST_P2: begin
          setup_lamp    <= 1'b1;
          alarm_lamp    <= 1'b1;
          bus_link_lamp <= 1'b1;
        end
        ST_P1: begin
          setup_lamp    <= 1'b1;
          alarm_lamp    <= slave_alarm_r;
          bus_link_lamp <= 1'b1;
        end
        default: begin
          setup_lamp    <= 1'b0;
          alarm_lamp    <= slave_alarm_r;
          bus_link_lamp <= 1'b1;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Bus cycle timer
  //--------------------------------------------------------------
  reg [18:0] cyc_cnt_r;
  reg [18:0] cyc_len;

  // Cycle length from the point setting
  always @* begin
    case (io_points_sel)
      `SBIC_PTS_128: cyc_len = CYC128_CNT[18:0]; // see RULE16
      `SBIC_PTS_256: cyc_len = CYC256_CNT[18:0];
      `SBIC_PTS_384: cyc_len = CYC384_CNT[18:0]; // see RULE17
      default:       cyc_len = CYC512_CNT[18:0];
    endcase
  end

  // Transmission never stops for address faults
  always @(posedge clk_sys) begin
    if (rst) begin
      cyc_cnt_r       <= 19'h00000;
      bus_cycle_stb_r <= 1'b0;
      bus_tx_run_r    <= 1'b0;
    end else begin
      bus_tx_run_r <= 1'b1; // see RULE6
      if (cyc_cnt_r >= cyc_len - 19'h00001) begin
        cyc_cnt_r       <= 19'h00000;
        bus_cycle_stb_r <= 1'b1;
      end else begin
        cyc_cnt_r       <= cyc_cnt_r + 19'h00001;
        bus_cycle_stb_r <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // Input double check and processing delays
  //--------------------------------------------------------------
  wire [IN_W-1:0] acc_data;
  wire            acc_upd;

  sbic_dchk #(
    .W (IN_W)
  ) u_dchk (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .rx_data    (bus_rx_data),
    .rx_stb     (bus_rx_stb),
    .acc_data_r (acc_data),
    .acc_upd_r  (acc_upd)
  );

  reg [15:0]     in_dly_r;
  reg            in_pend_r;
  reg [IN_W-1:0] in_hold_r;
  reg [15:0]     out_dly_r;
  reg [IN_W-1:0] out_prev_r;
  reg [IN_W-1:0] out_hold_r;

  // Input to host after processing time
  always @(posedge clk_sys) begin
    if (rst) begin
      in_dly_r       <= 16'h0000;
      in_pend_r      <= 1'b0;
      in_hold_r      <= {IN_W{1'b0}};
      host_in_data_r <= {IN_W{1'b0}};
      host_in_upd_r  <= 1'b0;
    end else begin
      host_in_upd_r <= 1'b0;
      if (acc_upd) begin
        in_hold_r <= acc_data;
        in_pend_r <= 1'b1;
        in_dly_r  <= PROC_CNT[15:0]; // see RULE21
      end else if (in_pend_r && in_dly_r == 16'h0001) begin
        in_pend_r      <= 1'b0;
        host_in_data_r <= in_hold_r;
        host_in_upd_r  <= 1'b1;
      end else if (in_pend_r) begin
        in_dly_r <= in_dly_r - 16'h0001;
      end
    end
  end

  // Host output to bus after processing time
  always @(posedge clk_sys) begin
    if (rst) begin
      out_dly_r     <= 16'h0000;
      out_prev_r    <= {IN_W{1'b0}};
      out_hold_r    <= {IN_W{1'b0}};
      bus_tx_data_r <= {IN_W{1'b0}};
    end else begin
      out_prev_r <= host_out_data;
      if (host_out_data != out_prev_r) begin
        out_hold_r <= host_out_data;
        out_dly_r  <= PROC_CNT[15:0]; // see RULE21
      end else if (out_dly_r == 16'h0001) begin
        out_dly_r     <= 16'h0000;
        bus_tx_data_r <= out_hold_r;
      end else if (out_dly_r != 16'h0000) begin
        out_dly_r <= out_dly_r - 16'h0001;
      end
    end
  end
endmodule // sbic_top

// >>> verification/sbic_slv.sv
// Slave module model: input words per bus cycle, output double check
`timescale 1ns/1ps
module sbic_slv (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Bus side of the block
  input  wire        bus_cycle_stb_r,
  input  wire [15:0] bus_tx_data_r,
  output reg  [15:0] bus_rx_data,
  output reg         bus_rx_stb,
  // Slave terminals
  input  wire [15:0] in_word,
  output reg  [15:0] out_word
);
  reg [15:0] tx_r;
  initial bus_rx_data = 16'h0;
  initial bus_rx_stb = 1'b0;
  // Answer each cycle; data is junk outside the strobe
  always @(posedge clk_sys) begin
    bus_rx_stb <= bus_cycle_stb_r && !rst;
    bus_rx_data <= bus_cycle_stb_r ? in_word : ~bus_rx_data;
    if (rst) begin
      out_word <= 16'h0;
      tx_r <= 16'h0;
    end else if (bus_cycle_stb_r) begin
      tx_r <= bus_tx_data_r;
      if (tx_r == bus_tx_data_r)
        out_word <= bus_tx_data_r;
    end
  end
endmodule // sbic_slv

// >>> verification/sbic_top_assertions.sv
// Port checker for the sensor bus ID check block
`timescale 1ns/1ps
module sbic_chk #(
  parameter CYC128_CNT = 20,
  parameter CYC256_CNT = 30,
  parameter CYC384_CNT = 40,
  parameter CYC512_CNT = 50
) (
  // Clock, reset and setup
  input wire        clk_sys,
  input wire        rst,
  input wire [1:0]  io_points_sel,
  input wire        ext_mode,
  // Detection results
  input wire        det_start,
  input wire        det_id_stb,
  input wire [11:0] det_id,
  input wire        det_dup,
  // Reports
  input wire        slave_alarm_r,
  input wire [15:0] latest_fault_code_word,
  input wire [15:0] latest_fault_id_word,
  input wire [9:0]  fault_id_brief_bits,
  input wire        host_alarm_r,
  input wire [7:0]  host_alarm_cnt_r,
  // Cycle and mode
  input wire        bus_cycle_stb_r,
  input wire        bus_tx_run_r,
  input wire        test_mode_r,
  input wire        host_comm_en_r,
  input wire        setup_lamp,
  input wire        alarm_lamp
);
  reg  [11:0] id_q;
  reg  [15:0] gap_r;
  reg         seen_r;
  reg  [1:0]  sel_r;
  wire unset = det_id == 12'h2FF || det_id == 12'h0FF;
  wire stb = det_id_stb && !det_start;
  wire hit = stb && (det_dup || unset);
  wire [15:0] exp_len = sel_r == 2'h0 ? CYC128_CNT : sel_r == 2'h1 ?
    CYC256_CNT : sel_r == 2'h2 ? CYC384_CNT : CYC512_CNT;
  // Last ID and spacing of cycle strobes
  always @(posedge clk_sys) begin
    id_q <= det_id;
    sel_r <= io_points_sel;
    if (rst || sel_r != io_points_sel) begin
      seen_r <= 1'b0;
      gap_r <= 16'h1;
    end else if (bus_cycle_stb_r) begin
      seen_r <= 1'b1;
      gap_r <= 16'h1;
    end else
      gap_r <= gap_r + 16'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_dup; stb && det_dup && !unset && ext_mode |=> host_alarm_r &&
    latest_fault_code_word == 16'h0190 &&
    latest_fault_id_word == {4'h0, id_q}; endproperty
  a_dup: assert property (p_dup) else $error("dup report");
  property p_unset; stb && !det_dup && unset && ext_mode |=>
    latest_fault_code_word == 16'h0191 &&
    latest_fault_id_word == {4'h0, id_q}; endproperty
  a_unset: assert property (p_unset) else $error("unset report");
  property p_brief;
    hit |=> slave_alarm_r && fault_id_brief_bits == id_q[9:0]; endproperty
  a_brief: assert property (p_brief) else $error("brief");
  property p_refuse; hit && !ext_mode |=>
    $stable(latest_fault_code_word) && $stable(host_alarm_r); endproperty
  a_refuse: assert property (p_refuse) else $error("mode");
  property p_cnt; host_alarm_r |-> host_alarm_cnt_r == 8'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("alarm count");
  property p_run; slave_alarm_r |-> bus_tx_run_r; endproperty
  a_run: assert property (p_run) else $error("tx stopped");
  property p_zero; $fell(slave_alarm_r) |-> !host_alarm_r &&
    latest_fault_code_word == 16'h0 && latest_fault_id_word == 16'h0 &&
    fault_id_brief_bits == 10'h0; endproperty
  a_zero: assert property (p_zero) else $error("not zeroed");
  property p_cyc; bus_cycle_stb_r && seen_r |-> gap_r == exp_len; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle");
  property p_test; test_mode_r |->
    !setup_lamp && !alarm_lamp && !host_comm_en_r; endproperty
  a_test: assert property (p_test) else $error("test lamps");
  property p_stay; test_mode_r |=> test_mode_r; endproperty
  a_stay: assert property (p_stay) else $error("test left");
endmodule // sbic_chk
bind sbic_top sbic_chk #(.CYC128_CNT(CYC128_CNT), .CYC256_CNT(CYC256_CNT),
  .CYC384_CNT(CYC384_CNT), .CYC512_CNT(CYC512_CNT)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .io_points_sel(io_points_sel),
  .ext_mode(ext_mode), .det_start(det_start), .det_id_stb(det_id_stb),
  .det_id(det_id), .det_dup(det_dup), .slave_alarm_r(slave_alarm_r),
  .latest_fault_code_word(latest_fault_code_word),
  .latest_fault_id_word(latest_fault_id_word),
  .fault_id_brief_bits(fault_id_brief_bits), .host_alarm_r(host_alarm_r),
  .host_alarm_cnt_r(host_alarm_cnt_r), .bus_cycle_stb_r(bus_cycle_stb_r),
  .bus_tx_run_r(bus_tx_run_r), .test_mode_r(test_mode_r),
  .host_comm_en_r(host_comm_en_r), .setup_lamp(setup_lamp),
  .alarm_lamp(alarm_lamp));

// >>> verification/tb_sensor_bus_id_check_cycle.sv
// Testbench for the sensor bus ID check and cycle block
`timescale 1ns/1ps
module tb_sensor_bus_id_check_cycle;
  logic clk_sys = 0, rst = 1, ext = 1, link = 0, cm = 0, ca = 0, btn = 0;
  logic dst = 0, dstb = 0, ddup = 0, dn = 0, rxs, alm, halm, cyc, run, upd;
  logic tm, hce, lset, lalm, llnk;
  logic [1:0]  sel = 0;
  logic [11:0] did = 0, hid;
  logic [15:0] hout = 0, inw = 0, rxd, txd, hin, sout, code, idw;
  logic [9:0]  brf;
  logic [7:0]  hcnt;
  int          n_mismatch = 0, cmp_count = 0;
  // Shortened timing for simulation
  localparam int CY0 = 20, CY1 = 30, CY2 = 40, CY3 = 50, PRC = 3, FLS = 4;
  always #20 clk_sys = ~clk_sys;
  sbic_top #(.CYC128_CNT(CY0), .CYC256_CNT(CY1), .CYC384_CNT(CY2),
    .CYC512_CNT(CY3), .PROC_CNT(PRC), .FLASH_CNT(FLS)) dut (
    .clk_sys(clk_sys), .rst(rst), .io_points_sel(sel), .ext_mode(ext),
    .host_link_pin(link), .fault_clear_request_main(cm),
    .fault_clear_request_alt(ca), .setup_btn_pin(btn), .det_start(dst),
    .det_id_stb(dstb), .det_id(did), .det_dup(ddup), .det_done(dn),
    .bus_rx_data(rxd), .bus_rx_stb(rxs), .host_out_data(hout),
    .slave_alarm_r(alm), .latest_fault_code_word(code),
    .latest_fault_id_word(idw), .fault_id_brief_bits(brf),
    .host_alarm_r(halm), .host_alarm_id_r(hid), .host_alarm_cnt_r(hcnt),
    .bus_cycle_stb_r(cyc), .bus_tx_run_r(run), .bus_tx_data_r(txd),
    .host_in_data_r(hin), .host_in_upd_r(upd), .test_mode_r(tm),
    .host_comm_en_r(hce), .setup_lamp(lset), .alarm_lamp(lalm),
    .bus_link_lamp(llnk));
  sbic_slv slv (.clk_sys(clk_sys), .rst(rst), .bus_cycle_stb_r(cyc),
    .bus_tx_data_r(txd), .bus_rx_data(rxd), .bus_rx_stb(rxs),
    .in_word(inw), .out_word(sout));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task tick; @(posedge clk_sys); #1; endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task tmo(input string w);
    n_mismatch++;
    $display("[FAIL] %s timeout", w);
    end_of_test;
  endtask
  task do_reset; rst = 1; repeat (6) tick; rst = 0; tick; endtask
  task det(input logic [11:0] id, input logic dup);
    dstb = 1; did = id; ddup = dup; tick; dstb = 0; ddup = 0;
  endtask
  // Two slave reports back to back, strobe held high between them
  task det2(input logic [11:0] a, b, input logic da, db);
    dstb = 1; did = a; ddup = da; tick;
    did = b; ddup = db; tick;
    dstb = 0; ddup = 0;
  endtask
  task start_det; dst = 1; tick; dst = 0; dn = 1; tick; dn = 0; endtask
  task press; btn = 1; repeat (5) tick; btn = 0; repeat (5) tick; endtask
  task wstb(output int n);
    n = 0;
    do begin
      tick;
      n++;
    end while (cyc !== 1'b1 && n < 200);
    if (n >= 200) tmo("cycle");
  endtask
  // Duplicate after a clean slave; repeated ID keeps one alarm
  task t_dup;
    start_det; det(12'h003, 0); tick;
    chk("clean", alm, 0);
    det2(12'h00A, 12'h00A, 1, 1); tick;
    chk("alarm", alm, 1);
    chk("code", code, 16'h0190);
    chk("id", idw, 16'h000A);
    chk("brief", brf, 16'h000A);
    chk("hid", hid, 16'h000A);
    chk("cnt", hcnt, 1);
    chk("run", run, 1);
  endtask
  // Both unset IDs, then back to back errors
  task t_unset;
    logic [11:0] ids [2];
    ids = '{12'h2FF, 12'h0FF};
    foreach (ids[k]) begin
      start_det; det(ids[k], 0); tick;
      chk("ucode", code, 16'h0191);
      chk("uid", idw, {4'h0, ids[k]});
      chk("ubrf", brf, ids[k][9:0]);
    end
    det2(12'h005, 12'h2FF, 1, 0); tick;
    chk("last", idw, 16'h02FF);
  endtask
  task t_refuse;
    start_det; ext = 0; det(12'h00A, 1); tick;
    chk("ralm", alm, 1);
    chk("rcode", code, 0);
    chk("rhost", halm, 0);
    ext = 1;
  endtask
  // Clear through each flag; a held flag does nothing
  task t_clear;
    int n;
    for (int k = 0; k < 2; k++) begin
      det(12'h00A, 1);
      {ca, cm} = k ? 2'h2 : 2'h1;
      repeat (8) tick;
      chk("held", alm, 1);
      {ca, cm} = 2'h0;
      n = 0;
      while (alm !== 1'b0 && n < 10) begin
        tick;
        n++;
      end
      chk("clr", alm, 0);
      chk("czero", code | idw | brf, 0);
    end
  endtask
  task t_cycle;
    int n;
    int lens [4];
    lens = '{CY0, CY1, CY2, CY3};
    for (int i = 0; i < 4; i++) begin
      sel = i[1:0];
      wstb(n);
      wstb(n);
      wstb(n);
      chk("cyc", n, lens[i]);
    end
    sel = 0;
  endtask
  // Input double check, short pulse refused, output path
  task t_io;
    int n;
    inw = 16'h1234; n = 0;
    while (!(upd === 1'b1 && hin === 16'h1234) && n < 100) begin
      tick;
      n++;
    end
    chk("inlat", n >= 23 && n <= 48, 1);
    wstb(n); inw = 16'h5555; wstb(n); inw = 16'h1234; n = 0;
    // A one cycle word must never reach the host side
    repeat (60) begin
      tick;
      n += (hin === 16'h5555);
    end
    chk("glitch", hin, 16'h1234);
    chk("gseen", n, 0);
    hout = 16'hBEEF; n = 0;
    while (txd !== 16'hBEEF && n < 20) begin
      tick;
      n++;
    end
    chk("outlat", n >= 3 && n < 20, 1);
    repeat (60) tick;
    chk("slave", sout, 16'hBEEF);
  endtask
  task t_test;
    int t;
    det(12'h00A, 1); do_reset;
    chk("pwr", alm, 0);
    press;
    chk("p1", {lset, lalm}, 2);
    press;
    chk("p2", {lset, lalm}, 3);
    press;
    chk("tm", {tm, hce, lset, lalm}, 8);
    t = 0;
    repeat (20) begin
      tick;
      t += (llnk !== 1'b1);
    end
    chk("flash", t > 4 && t < 16, 1);
    link = 1; repeat (10) tick;
    chk("stay", tm, 1);
    do_reset; press; press; press;
    chk("link", tm, 0);
    link = 0;
  endtask
  initial begin
    do_reset;
    t_dup;
    t_unset;
    t_refuse;
    t_clear;
    t_cycle;
    t_io;
    t_test;
    end_of_test;
  end
endmodule // tb_sensor_bus_id_check_cycle
